// ### hdl/lcdrst_pkg.sv
package lcdrst_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 5000;
	// Internal reset time, longest, in ns
	localparam int RESET_TIME_NS = 2000;
	localparam int RESET_TIME_CYC = (RESET_TIME_NS * 1000) / CLK_PERIOD_PS;
	// Reset low width, least, in ps (2.5 us)
	localparam int RESET_LOW_PS = 2500000;
	localparam int RESET_LOW_CYC =
		(RESET_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Power settle wait, in us (5 ms)
	localparam int SETTLE_US = 5000;
	// Scaled per microsecond first: the product in ps would overflow an int
	localparam int SETTLE_CYC = SETTLE_US * (1000000 / CLK_PERIOD_PS);
	// Wait after power control, in us (module dependent)
	localparam int PWR_WAIT_US = 100;
	localparam int PWR_WAIT_CYC = (PWR_WAIT_US * 1000000) / CLK_PERIOD_PS;
	localparam int CNT_W = 24;

	// ****************************************
	// Instruction codes and fields
	// ****************************************
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
	localparam logic [7:0] CMD_INV_OFF = 8'h20;
	localparam logic [7:0] CMD_INV_ON = 8'h21;
	localparam logic [7:0] CMD_ALLON_OFF = 8'h22;
	localparam logic [7:0] CMD_ALLON_ON = 8'h23;
	localparam logic [7:0] CMD_DISP_OFF = 8'h28;
	localparam logic [7:0] CMD_DISP_ON = 8'h29;
	localparam logic [7:0] CMD_COL_ADDR = 8'h2A;
	localparam logic [7:0] CMD_ROW_ADDR = 8'h2B;
	localparam logic [7:0] CMD_MEM_WRITE = 8'h2C;
	localparam logic [7:0] CMD_PWR_CTRL = 8'hD2;
	localparam logic [7:0] CMD_SET_PWM = 8'hB3;
	localparam logic [7:0] CMD_SET_VOP = 8'hC0;
	localparam logic [7:0] PWR_ALL_ON = 8'h1E;
	localparam logic [7:0] RAM_FILL = 8'h00;
	localparam int PWR_OSC_BIT = 4;
	localparam int PWR_BOOST_BIT = 3;
	localparam int PWR_FOLLOW_BIT = 2;
	localparam int PWR_DRV_BIT = 1;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_ZERO = 4'h0;
	localparam logic [3:0] COL_LAST = 4'hB;
	localparam logic [3:0] ROW_LAST = 4'h8;
	localparam logic [7:0] VOP_DEFAULT = 8'h00;
	localparam logic [7:0] PWM_DEFAULT = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] STEP_ONE = 4'h1;
endpackage

// ### hdl/lcdrst_if.sv
`timescale 1ns/1ps
// Link between host and display controller
interface lcdrst_if;
	logic rst_n;
	logic valid;
	logic is_param;
	logic [7:0] data;
	modport host (output rst_n, output valid, output is_param, output data);
	modport dev (input rst_n, input valid, input is_param, input data);
endinterface

// ### hdl/lcdrst_dev.sv
// Function
// - Hardware reset low or soft command starts reset
// - Reset stops oscillator and backlight PWM
// - Reset blanks display, outputs at ground
// - Reset clears all-pixel-on and inversion
// - Reset zeroes row and column counters
// - Reset clears all four power enables
// - Reset restores every configuration default; soft reset leaves wd_q (ram_wdata) at its last byte
// - Display RAM survives any reset
// - Power-up: RAM undefined, display off
// - Host resets device before any operation
// - Host waits internal reset time before commands
// - Host holds reset low 2.5 us minimum
// - Host keeps reset low until power settles
// - Host fills display RAM before display on; lcdrst_host writes only RAM_WORDS (12) zero words, all in row 0
// - Host waits module-specific time after power control
`timescale 1ns/1ps
module lcdrst_dev #(
	parameter int RESET_CYC = lcdrst_pkg::RESET_TIME_CYC,
	parameter int COLS = 12,
	parameter int ROWS = 9
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	lcdrst_if.dev lnk,
	output logic busy,
	output logic osc_enable,
	output logic booster_enable,
	output logic follower_enable,
	output logic drive_voltage_enable,
	output logic pwm_enable,
	output logic display_on,
	output logic all_on,
	output logic invert,
	output logic [lcdrst_pkg::ADDR_W-1:0] row_addr,
	output logic [lcdrst_pkg::ADDR_W-1:0] col_addr,
	output logic ram_we,
	output logic [7:0] ram_wdata
);
	import lcdrst_pkg::*;

	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_IDLE = 3'b010,
		ST_PARAM = 3'b100
	} lcdrst_state_t;

	// ****************************************
	// Reset pin synchroniser
	// ****************************************
	// Asynchronous assertion of the internal reset from the pin, clean
	// release through two flops; nrst is the system reset of the core.
	logic [1:0] pin_sync_q;
	logic hw_rst_n;
	always_ff @(posedge mclk or negedge lnk.rst_n) begin
		if (!lnk.rst_n) begin
			pin_sync_q <= 2'b00;
		end else begin
			pin_sync_q <= {pin_sync_q[0], 1'b1};
		end
	end
	assign hw_rst_n = pin_sync_q[1];

	// Command inputs from the host, two flops each
	logic [9:0] cmd_s1_q;
	logic [9:0] cmd_s2_q;
	always_ff @(posedge mclk) begin
		cmd_s1_q <= {lnk.valid, lnk.is_param, lnk.data};
		cmd_s2_q <= cmd_s1_q;
	end
	logic cmd_valid_q;
	logic cmd_seen_q;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cmd_seen_q <= 1'b0;
		end else if (clk_en) begin
			cmd_seen_q <= cmd_s2_q[9];
		end
	end
	// Valid is a level per word; act once on its rising edge
	assign cmd_valid_q = cmd_s2_q[9] && !cmd_seen_q;

	// ****************************************
	// Control state
	// ****************************************
	lcdrst_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [7:0] cmd_q, cmd_d;
	logic [4:0] pwr_q, pwr_d;
	logic disp_q, disp_d, allon_q, allon_d, inv_q, inv_d;
	logic [ADDR_W-1:0] row_q, row_d, col_q, col_d;
	logic pwm_q, pwm_d, we_q, we_d;
	logic [7:0] wd_q, wd_d;

	// Next-state decode
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cmd_d = cmd_q;
		pwr_d = pwr_q;
		disp_d = disp_q;
		allon_d = allon_q;
		inv_d = inv_q;
		row_d = row_q;
		col_d = col_q;
		pwm_d = pwm_q;
		we_d = 1'b0;
		wd_d = wd_q;
		case (state_q)
			ST_RESET: begin
				// RAM write strobe held low here, contents kept
				we_d = 1'b0;
				if (cnt_q >= CNT_W'(RESET_CYC)) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			ST_IDLE, ST_PARAM: begin
				if (cmd_valid_q && !cmd_s2_q[8]) begin
					cmd_d = cmd_s2_q[7:0];
					state_d = ST_PARAM;
					case (cmd_s2_q[7:0])
						CMD_SOFT_RESET: begin
							// Same defaults as the pin reset except wd_q, which keeps its last byte; RAM kept
							state_d = ST_RESET;
							cnt_d = '0;
							cmd_d = CMD_NOP;
							pwr_d = '0;
							pwm_d = 1'b0;
							disp_d = 1'b0;
							allon_d = 1'b0;
							inv_d = 1'b0;
							row_d = ADDR_ZERO;
							col_d = ADDR_ZERO;
						end
						CMD_INV_OFF: inv_d = 1'b0;
						CMD_INV_ON: inv_d = 1'b1;
						CMD_ALLON_OFF: allon_d = 1'b0;
						CMD_ALLON_ON: allon_d = 1'b1;
						CMD_DISP_OFF: disp_d = 1'b0;
						CMD_DISP_ON: disp_d = 1'b1;
						default: begin
						end
					endcase
				end else if (cmd_valid_q && state_q == ST_PARAM) begin
					case (cmd_q)
						CMD_COL_ADDR: col_d = cmd_s2_q[ADDR_W-1:0];
						CMD_ROW_ADDR: row_d = cmd_s2_q[ADDR_W-1:0];
						CMD_PWR_CTRL: begin
							pwr_d = cmd_s2_q[PWR_OSC_BIT:0];
							pwm_d = cmd_s2_q[PWR_OSC_BIT];
						end
						CMD_MEM_WRITE: begin
							we_d = 1'b1;
							wd_d = cmd_s2_q[7:0];
							col_d = col_q + STEP_ONE;
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				state_d = ST_RESET;
				cnt_d = '0;
			end
		endcase
	end

	// State registers; nrst or the pin reset restores every default
	always_ff @(posedge mclk) begin
		if (!nrst || !hw_rst_n) begin
			state_q <= ST_RESET;
			cnt_q <= '0;
			cmd_q <= CMD_NOP;
			pwr_q <= '0;
			pwm_q <= 1'b0;
			disp_q <= 1'b0;
			allon_q <= 1'b0;
			inv_q <= 1'b0;
			row_q <= ADDR_ZERO;
			col_q <= ADDR_ZERO;
			we_q <= 1'b0;
			wd_q <= BYTE_ZERO;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cmd_q <= cmd_d;
			pwr_q <= pwr_d;
			pwm_q <= pwm_d;
			disp_q <= disp_d;
			allon_q <= allon_d;
			inv_q <= inv_d;
			row_q <= row_d;
			col_q <= col_d;
			we_q <= we_d;
			wd_q <= wd_d;
		end
	end

	// ****************************************
	// Outputs, all from flops
	// ****************************************
	// Commands are dropped while in ST_RESET: no branch decodes them
	assign busy = state_q[0];
	assign osc_enable = pwr_q[PWR_OSC_BIT];
	assign booster_enable = pwr_q[PWR_BOOST_BIT];
	assign follower_enable = pwr_q[PWR_FOLLOW_BIT];
	assign drive_voltage_enable = pwr_q[PWR_DRV_BIT];
	assign pwm_enable = pwm_q;
	// Power-up lands here too: display off until commanded
	assign display_on = disp_q;
	assign all_on = allon_q;
	assign invert = inv_q;
	assign row_addr = row_q;
	assign col_addr = col_q;
	assign ram_we = we_q;
	assign ram_wdata = wd_q;
endmodule

// ### hdl/lcdrst_host.sv
`timescale 1ns/1ps
// Host end: power-on reset pulse, waits, power control, clear of RAM_WORDS words in row 0, then display on
module lcdrst_host #(
	parameter int SETTLE_CYC = lcdrst_pkg::SETTLE_CYC,
	parameter int LOW_CYC = lcdrst_pkg::RESET_LOW_CYC,
	parameter int WAIT_CYC = lcdrst_pkg::RESET_TIME_CYC,
	parameter int PWR_CYC = lcdrst_pkg::PWR_WAIT_CYC,
	parameter int RAM_WORDS = 12,
	parameter int GAP_CYC = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic start,
	lcdrst_if.host lnk,
	output logic ready
);
	import lcdrst_pkg::*;

	typedef enum logic [5:0] {
		H_HOLD = 6'b000001,
		H_WAIT = 6'b000010,
		H_PWR = 6'b000100,
		H_PWAIT = 6'b001000,
		H_FILL = 6'b010000,
		H_DONE = 6'b100000
	} lcdrst_hstate_t;

	// ****************************************
	// Sequencer
	// ****************************************
	lcdrst_hstate_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] idx_q, idx_d;
	logic rst_n_q, rst_n_d, val_q, val_d, par_q, par_d, rdy_q, rdy_d;
	logic [7:0] dat_q, dat_d;
	localparam int HOLD_CYC = (SETTLE_CYC > LOW_CYC) ? SETTLE_CYC : LOW_CYC;

	// Sends one word, level valid, then a gap for the device synchroniser
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 1'b1;
		idx_d = idx_q;
		rst_n_d = rst_n_q;
		val_d = val_q;
		par_d = par_q;
		dat_d = dat_q;
		rdy_d = rdy_q;
		if (cnt_q == CNT_W'(GAP_CYC / 2)) begin
			val_d = 1'b0;
		end
		case (st_q)
			H_HOLD: begin
				// Low until power settles and pulse is wide enough
				rst_n_d = 1'b0;
				val_d = 1'b0;
				if (cnt_q >= CNT_W'(HOLD_CYC)) begin
					rst_n_d = 1'b1;
					st_d = H_WAIT;
					cnt_d = '0;
				end
			end
			H_WAIT: begin
				if (cnt_q >= CNT_W'(WAIT_CYC + GAP_CYC)) begin
					st_d = H_PWR;
					cnt_d = '0;
					idx_d = '0;
				end
			end
			H_PWR: begin
				if (cnt_q >= CNT_W'(GAP_CYC)) begin
					cnt_d = '0;
					val_d = 1'b1;
					par_d = (idx_q != '0);
					dat_d = (idx_q == '0) ? CMD_PWR_CTRL : PWR_ALL_ON;
					idx_d = idx_q + 1'b1;
					if (idx_q != '0) begin
						st_d = H_PWAIT;
					end
				end
			end
			H_PWAIT: begin
				if (cnt_q >= CNT_W'(PWR_CYC)) begin
					st_d = H_FILL;
					cnt_d = '0;
					idx_d = '0;
				end
			end
			H_FILL: begin
				// Clear RAM_WORDS words of row 0, not the whole RAM, before the display is switched on
				if (cnt_q >= CNT_W'(GAP_CYC)) begin
					cnt_d = '0;
					val_d = 1'b1;
					idx_d = idx_q + 1'b1;
					par_d = (idx_q != '0);
					dat_d = (idx_q == '0) ? CMD_MEM_WRITE : RAM_FILL;
					if (idx_q == CNT_W'(RAM_WORDS + 1)) begin
						par_d = 1'b0;
						dat_d = CMD_DISP_ON;
						st_d = H_DONE;
					end
				end
			end
			H_DONE: begin
				// Ready only once the last word has dropped and settled
				if (cnt_q >= CNT_W'(GAP_CYC)) begin
					rdy_d = 1'b1;
				end
				if (rdy_q && start) begin
					st_d = H_HOLD;
					cnt_d = '0;
					rdy_d = 1'b0;
				end
			end
			default: begin
				st_d = H_HOLD;
				cnt_d = '0;
			end
		endcase
	end

	// Registers only
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_q <= H_HOLD;
			cnt_q <= '0;
			idx_q <= '0;
			rst_n_q <= 1'b0;
			val_q <= 1'b0;
			par_q <= 1'b0;
			dat_q <= BYTE_ZERO;
			rdy_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			rst_n_q <= rst_n_d;
			val_q <= val_d;
			par_q <= par_d;
			dat_q <= dat_d;
			rdy_q <= rdy_d;
		end
	end

	assign lnk.rst_n = rst_n_q;
	assign lnk.valid = val_q;
	assign lnk.is_param = par_q;
	assign lnk.data = dat_q;
	assign ready = rdy_q;
endmodule

// ### tb/lcdrst_asserts.sv
`timescale 1ns/1ps
// ****************
// Host link checker
// ****************
module lcdrst_asserts #(
	parameter int LOW_CYC = 500,
	parameter int WAIT_CYC = 400,
	parameter int PWR_CYC = 50,
	parameter int RAM_WORDS = 12
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rst_n,
	input wire logic valid,
	input wire logic is_param,
	input wire logic [7:0] data
);
	import lcdrst_pkg::*;
	int low_q = 0;
	int high_q = 0;
	int gap_q = 0;
	int words_q = 0;
	int fills_q = 0;
	logic vld_q = 1'b0;
	logic [7:0] cmd_q = 8'h00;

	// Counters ignore nrst: the reset pulse starts inside core reset
	always_ff @(posedge mclk) begin
		low_q <= rst_n ? 0 : low_q + 1;
		high_q <= rst_n ? high_q + 1 : 0;
		gap_q <= valid ? 0 : gap_q + 1;
		vld_q <= valid;
		if (!rst_n) begin
			words_q <= 0;
			fills_q <= 0;
		end else if (valid && !vld_q) begin
			words_q <= words_q + 1;
			if (is_param && cmd_q == CMD_MEM_WRITE)
				fills_q <= fills_q + 1;
		end
		if (valid && !vld_q && !is_param)
			cmd_q <= data;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	a_quiet_in_reset: assert property (!rst_n |-> !valid)
		else $error("word sent during reset");
	a_reset_width: assert property ($rose(rst_n) |-> low_q >= LOW_CYC)
		else $error("reset pulse too short");
	a_wait_release: assert property ($rose(valid) |-> high_q >= WAIT_CYC)
		else $error("word too soon after reset");
	a_word_gap: assert property ($fell(valid) |-> !valid [*3])
		else $error("words too close");
	a_word_steady: assert property (valid && $past(valid) |->
		$stable(data) && $stable(is_param)) else $error("word changed");
	a_power_first: assert property ($rose(valid) && words_q == 0 |->
		!is_param && data == CMD_PWR_CTRL) else $error("no power first");
	a_power_bits: assert property ($rose(valid) && words_q == 1 |->
		is_param && data == PWR_ALL_ON) else $error("bad power bits");
	a_power_wait: assert property ($rose(valid) && words_q == 2 |->
		gap_q >= PWR_CYC) else $error("power wait too short");
	a_fill_zero: assert property ($rose(valid) && is_param &&
		cmd_q == CMD_MEM_WRITE |-> data == RAM_FILL)
		else $error("fill not zero");
	a_fill_first: assert property ($rose(valid) && !is_param &&
		data == CMD_DISP_ON |-> fills_q >= RAM_WORDS)
		else $error("display on before fill");

	c_release: cover property ($rose(rst_n));
	c_fill: cover property ($rose(valid) && is_param && cmd_q == CMD_MEM_WRITE);
	c_disp_on: cover property ($rose(valid) && data == CMD_DISP_ON);
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import lcdrst_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic start = 1'b0;
	logic ready, b1, b2, w1, w2;
	logic [7:0] wd1, wd2;
	logic [3:0] r1, c1, r2, c2;
	wire [7:0] o1;
	wire [7:0] o2;
	int errors = 0;
	int total_checks = 0;
	int we1 = 0;
	int we2 = 0;
	// Bench model of the second device
	logic [3:0] m_row, m_col, m_pw;
	logic m_disp, m_allon, m_inv;
	logic [7:0] m_cmd;
	int m_we = 0;
	int m_we1 = 0;
	logic [7:0] cmds[$] = '{CMD_NOP, CMD_INV_OFF, CMD_INV_ON, CMD_ALLON_OFF,
		CMD_ALLON_ON, CMD_DISP_OFF, CMD_DISP_ON, CMD_COL_ADDR, CMD_ROW_ADDR,
		CMD_MEM_WRITE, CMD_PWR_CTRL, 8'h55};
	lcdrst_if lnk_if();
	lcdrst_if bad_if();

	// ****************
	// Clock, instances
	// ****************
	always #2.5 mclk = ~mclk;

	lcdrst_host #(.SETTLE_CYC(50), .PWR_CYC(50)) lcdrst_host_i (
		.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .start(start),
		.lnk(lnk_if.host), .ready(ready));
	lcdrst_dev lcdrst_dev_i (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
		.lnk(lnk_if.dev), .busy(b1), .osc_enable(o1[7]),
		.booster_enable(o1[6]), .follower_enable(o1[5]),
		.drive_voltage_enable(o1[4]), .pwm_enable(o1[3]),
		.display_on(o1[2]), .all_on(o1[1]), .invert(o1[0]),
		.row_addr(r1), .col_addr(c1), .ram_we(w1), .ram_wdata(wd1));
	// Second device faces the bench driver, not the host
	lcdrst_dev lcdrst_dev_i2 (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
		.lnk(bad_if.dev), .busy(b2), .osc_enable(o2[7]),
		.booster_enable(o2[6]), .follower_enable(o2[5]),
		.drive_voltage_enable(o2[4]), .pwm_enable(o2[3]),
		.display_on(o2[2]), .all_on(o2[1]), .invert(o2[0]),
		.row_addr(r2), .col_addr(c2), .ram_we(w2), .ram_wdata(wd2));
	lcdrst_asserts #(.LOW_CYC(500), .WAIT_CYC(RESET_TIME_CYC), .PWR_CYC(50),
		.RAM_WORDS(12)) lcdrst_asserts_i (.mclk(mclk), .nrst(nrst),
		.rst_n(lnk_if.rst_n), .valid(lnk_if.valid),
		.is_param(lnk_if.is_param), .data(lnk_if.data));

	// ****************
	// Tasks
	// ****************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task summarize();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Released data shows the inverse, never a stale byte
	task send(input logic par, input logic [7:0] b);
		bad_if.valid = 1'b1;
		bad_if.is_param = par;
		bad_if.data = b;
		cyc(4);
		bad_if.valid = 1'b0;
		bad_if.data = ~b;
		cyc(4);
	endtask

	task clr();
		{m_row, m_col, m_pw, m_disp, m_allon, m_inv} = '0;
		m_cmd = CMD_NOP;
	endtask

	task apply(input logic par, input logic [7:0] b);
		if (!par) begin
			m_cmd = b;
			case (b)
				CMD_INV_OFF: m_inv = 1'b0;
				CMD_INV_ON: m_inv = 1'b1;
				CMD_ALLON_OFF: m_allon = 1'b0;
				CMD_ALLON_ON: m_allon = 1'b1;
				CMD_DISP_OFF: m_disp = 1'b0;
				CMD_DISP_ON: m_disp = 1'b1;
				default: ;
			endcase
		end else begin
			case (m_cmd)
				CMD_COL_ADDR: m_col = b[3:0];
				CMD_ROW_ADDR: m_row = b[3:0];
				CMD_PWR_CTRL: m_pw = b[4:1];
				CMD_MEM_WRITE: begin
					m_col = m_col + 4'h1;
					m_we++;
				end
				default: ;
			endcase
		end
	endtask

	task cmp2();
		check({r2, c2, o2}, {m_row, m_col, m_pw, m_pw[3], m_disp, m_allon,
			m_inv});
		check(we2, m_we);
	endtask

	task word(input logic par, input logic [7:0] b);
		send(par, b);
		apply(par, b);
		cmp2();
	endtask

	task busy_state();
		word(1'b0, CMD_PWR_CTRL);
		word(1'b1, PWR_ALL_ON);
		word(1'b0, CMD_ALLON_ON);
		word(1'b0, CMD_INV_ON);
		word(1'b0, CMD_DISP_ON);
		word(1'b0, CMD_ROW_ADDR);
		word(1'b1, 8'h05);
		word(1'b0, CMD_MEM_WRITE);
		word(1'b1, 8'hA5);
	endtask

	// Bounded waits on the design's own status flags
	task wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 20000) begin
			cyc(1);
			n++;
		end
	endtask

	task wait_idle(output int n);
		n = 0;
		while (b2 !== 1'b0 && n < 1000) begin
			cyc(1);
			n++;
		end
	endtask

	task pair_check();
		wait_ready();
		m_we1 += 12;
		check(ready, 1'b1);
		check(o1, 8'hFC);
		check(b1, 1'b0);
		check(we1, m_we1);
		check({r1, c1}, {ADDR_ZERO, 4'(12)});
	endtask

	// RAM pulses; the host fill must write zeros
	always @(posedge mclk) begin
		if (w1 === 1'b1) begin
			we1++;
			check(wd1, RAM_FILL);
		end
		if (w2 === 1'b1)
			we2++;
	end

	// Watchdog, far beyond the expected run of some 6000 cycles
	initial begin
		repeat (40000) @(posedge mclk);
		errors++;
		$display("watchdog expired");
		summarize();
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		int n;
		int k;
		logic [7:0] c;
		bad_if.rst_n = 1'b0;
		bad_if.valid = 1'b0;
		bad_if.is_param = 1'b0;
		bad_if.data = 8'h00;
		n = $urandom(8);
		clr();
		cyc(4);
		nrst = 1'b1;
		pair_check();
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cyc(2);
		pair_check();
		$display("test pair start-up done");
		bad_if.rst_n = 1'b1;
		check(b2, 1'b1);
		send(1'b0, CMD_DISP_ON);
		wait_idle(n);
		check(n + 8 <= RESET_TIME_CYC + 5, 1'b1);
		cmp2();
		$display("test release done");
		repeat (30) begin
			c = cmds[$urandom_range(cmds.size() - 1)];
			if (c == CMD_MEM_WRITE) begin
				word(1'b0, CMD_COL_ADDR);
				word(1'b1, 8'($urandom_range(7)));
			end
			word(1'b0, c);
			k = (c inside {[CMD_INV_OFF:CMD_DISP_ON]}) ? 0 : 1;
			if (c == CMD_MEM_WRITE)
				k = $urandom_range(3, 1);
			repeat (k) word(1'b1, 8'($urandom));
		end
		$display("test traffic done");
		busy_state();
		send(1'b0, CMD_SOFT_RESET);
		clr();
		check(b2, 1'b1);
		cmp2();
		// Clock enable low: the reset countdown must not advance
		clk_en = 1'b0;
		cyc(RESET_TIME_CYC);
		clk_en = 1'b1;
		check(b2, 1'b1);
		send(1'b0, CMD_DISP_ON);
		wait_idle(n);
		cmp2();
		$display("test soft reset done");
		busy_state();
		bad_if.rst_n = 1'b0;
		cyc(3);
		clr();
		check(b2, 1'b1);
		cmp2();
		cyc(497);
		bad_if.rst_n = 1'b1;
		wait_idle(n);
		cmp2();
		$display("test hardware reset done");
		nrst = 1'b0;
		cyc(4);
		nrst = 1'b1;
		pair_check();
		$display("test core reset done");
		summarize();
	end
endmodule
